// >>> gpio_bank_pkg.sv
// constants for the general-purpose pin bank register map and fields
`default_nettype none
package gpio_bank_pkg;
   // register byte addresses
   localparam logic [11:0] BIDIR_REG_ADDR     = 12'h300;
   localparam logic [11:0] DEDICATED_REG_ADDR = 12'h304;
   localparam int          ADDR_W             = 12;
   // bidirectional group: three pins
   localparam int          BIDIR_N            = 3;
   localparam int          BIDIR_OUT_CLR_LSB  = 0;
   localparam int          BIDIR_OUT_SET_LSB  = 3;
   localparam int          BIDIR_EN_CLR_LSB   = 6;
   localparam int          BIDIR_EN_SET_LSB   = 9;
   localparam int          BIDIR_IN_LSB       = 12;
   // dedicated group: four outputs, four inputs
   localparam int          DED_N              = 4;
   localparam int          DED_OUT_CLR_LSB    = 0;
   localparam int          DED_OUT_SET_LSB    = 4;
   localparam int          DED_EN_CLR_LSB     = 8;
   localparam int          DED_EN_SET_LSB     = 12;
   localparam int          DED_IN_LSB         = 16;
   // reset values
   localparam logic [31:0] REG_RESET          = 32'h0000_0000;
   // axi responses
   localparam logic [1:0]  RESP_OKAY          = 2'h0;
   localparam logic [1:0]  RESP_SLVERR        = 2'h2;
endpackage
`default_nettype wire

// >>> pin_sync.sv
// two-flop synchroniser for a bus of pin levels
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk_i,
   input  wire logic         resetn_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_reg;   // first stage, read only by second stage

   // two stages, reset to zero
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         meta_reg <= '0;
         sync_o   <= '0;
      end
      else
      begin
         meta_reg <= async_i;
         sync_o   <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// >>> gpio_bank.sv
// general-purpose pin bank with axi4-lite register access
`default_nettype none
// What this block does
// - write one clears bidir output latch
// - write one sets bidir output latch
// - write one clears bidir pin enable
// - write one sets bidir pin enable
// - write one clears dedicated output latch
// - write one sets dedicated output latch
// - write one clears dedicated output enable
// - write one sets dedicated output enable
// - input fields read pin levels, ignore writes
module gpio_bank #(
   parameter int BIDIR_N = gpio_bank_pkg::BIDIR_N,
   parameter int DED_N   = gpio_bank_pkg::DED_N
) (
   input  wire logic               core_clk_i,
   input  wire logic               resetn_i,
   // axi4-lite write address
   input  wire logic [31:0]        s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   // axi4-lite write response
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   // axi4-lite read address
   input  wire logic [31:0]        s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   // axi4-lite read data
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   // bidirectional pins 6:4
   input  wire logic [BIDIR_N-1:0] bidir_pin_i,
   output logic      [BIDIR_N-1:0] bidir_pin_o,
   output logic      [BIDIR_N-1:0] bidir_pin_oe_o,
   // dedicated pins
   output logic      [DED_N-1:0]   dedicated_output_pin_o,
   output logic      [DED_N-1:0]   dedicated_output_pin_oe_o,
   input  wire logic [DED_N-1:0]   dedicated_input_pin_i
);
   // write channel state
   typedef enum logic [1:0] {W_IDLE, W_RESP} wr_state_t;

   wr_state_t          wr_state_reg;     // write sequencer
   logic               aw_held_reg;      // address captured
   logic               w_held_reg;       // data captured
   logic [31:0]        awaddr_reg;       // captured write address
   logic [31:0]        wdata_reg;        // captured write data
   logic [3:0]         wstrb_reg;        // captured strobes
   logic               wr_fire;          // both halves present
   logic [31:0]        wr_addr_eff;      // address used this cycle
   logic [31:0]        wr_data_eff;      // data used this cycle
   logic [3:0]         wr_strb_eff;      // strobes used this cycle
   logic [31:0]        wr_mask;          // per-bit write mask from strobes
   logic               wr_bidir;         // write hits bidir register
   logic               wr_ded;           // write hits dedicated register
   logic [31:0]        wbits;            // masked write ones

   logic [BIDIR_N-1:0] bidir_out_reg;    // bidir output latches
   logic [BIDIR_N-1:0] bidir_en_reg;     // bidir driver enables
   logic [DED_N-1:0]   ded_out_reg;      // dedicated output latches
   logic [DED_N-1:0]   ded_en_reg;       // dedicated driver enables
   logic [BIDIR_N-1:0] bidir_in_sync;    // synchronised bidir levels
   logic [DED_N-1:0]   ded_in_sync;      // synchronised input levels

   // word decode shared by read and write paths
   function automatic logic [1:0] decode(input logic [31:0] addr);
      logic [1:0] hit;
      hit = 2'h0;
      if (addr[gpio_bank_pkg::ADDR_W-1:2] == gpio_bank_pkg::BIDIR_REG_ADDR[11:2]
          && addr[31:gpio_bank_pkg::ADDR_W] == '0)
      begin
         hit = 2'h1;
      end
      else if (addr[gpio_bank_pkg::ADDR_W-1:2] == gpio_bank_pkg::DEDICATED_REG_ADDR[11:2]
               && addr[31:gpio_bank_pkg::ADDR_W] == '0)
      begin
         hit = 2'h2;
      end
      return hit;
   endfunction

   // input pins cross into the core clock domain
   pin_sync #(.W(BIDIR_N)) u_bidir_sync (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .async_i    (bidir_pin_i),
      .sync_o     (bidir_in_sync)
   );

   pin_sync #(.W(DED_N)) u_ded_sync (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .async_i    (dedicated_input_pin_i),
      .sync_o     (ded_in_sync)
   );

   // ready while the half is not yet held and no response pending
   assign s_axi_awready = !aw_held_reg && (wr_state_reg == W_IDLE);
   assign s_axi_wready  = !w_held_reg && (wr_state_reg == W_IDLE);

   // effective halves: either held or arriving now
   assign wr_addr_eff = aw_held_reg ? awaddr_reg : s_axi_awaddr;
   assign wr_data_eff = w_held_reg ? wdata_reg : s_axi_wdata;
   assign wr_strb_eff = w_held_reg ? wstrb_reg : s_axi_wstrb;
   assign wr_fire = (wr_state_reg == W_IDLE)
                    && (aw_held_reg || s_axi_awvalid)
                    && (w_held_reg || s_axi_wvalid);

   // strobe expansion and decode
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         wr_mask[i*8 +: 8] = {8{wr_strb_eff[i]}};
      end
      wbits    = wr_data_eff & wr_mask;
      wr_bidir = wr_fire && (decode(wr_addr_eff) == 2'h1);
      wr_ded   = wr_fire && (decode(wr_addr_eff) == 2'h2);
   end

   // capture address and data halves in either order
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= '0;
         wdata_reg   <= '0;
         wstrb_reg   <= '0;
      end
      else if (wr_fire)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
      end
      else
      begin
         // address alone
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         // data alone
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
      end
   end

   // write response sequencer
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wr_state_reg <= W_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= gpio_bank_pkg::RESP_OKAY;
      end
      else
      begin
         case (wr_state_reg)
            W_IDLE:
            begin
               if (wr_fire)
               begin
                  wr_state_reg <= W_RESP;
                  s_axi_bvalid <= 1'b1;
                  // unmapped address answers slverr
                  s_axi_bresp  <= (wr_bidir || wr_ded) ? gpio_bank_pkg::RESP_OKAY
                                                       : gpio_bank_pkg::RESP_SLVERR;
               end
            end
            W_RESP:
            begin
               if (s_axi_bready)
               begin
                  wr_state_reg <= W_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default:
            begin
               wr_state_reg <= W_IDLE;
            end
         endcase
      end
   end

   // bidir latches and enables; set applied after clear so set wins
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         bidir_out_reg <= '0;
         bidir_en_reg  <= '0;
      end
      else if (wr_bidir)
      begin
         bidir_out_reg <= (bidir_out_reg
                           & ~wbits[gpio_bank_pkg::BIDIR_OUT_CLR_LSB +: BIDIR_N])
                          | wbits[gpio_bank_pkg::BIDIR_OUT_SET_LSB +: BIDIR_N];
         bidir_en_reg  <= (bidir_en_reg
                           & ~wbits[gpio_bank_pkg::BIDIR_EN_CLR_LSB +: BIDIR_N])
                          | wbits[gpio_bank_pkg::BIDIR_EN_SET_LSB +: BIDIR_N];
      end
   end

   // dedicated latches and enables; set applied after clear
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ded_out_reg <= '0;
         ded_en_reg  <= '0;
      end
      else if (wr_ded)
      begin
         ded_out_reg <= (ded_out_reg
                         & ~wbits[gpio_bank_pkg::DED_OUT_CLR_LSB +: DED_N])
                        | wbits[gpio_bank_pkg::DED_OUT_SET_LSB +: DED_N];
         ded_en_reg  <= (ded_en_reg
                         & ~wbits[gpio_bank_pkg::DED_EN_CLR_LSB +: DED_N])
                        | wbits[gpio_bank_pkg::DED_EN_SET_LSB +: DED_N];
      end
   end

   // pins: value forced low while not enabled; oe low leaves the pin undriven
   assign bidir_pin_o               = bidir_out_reg & bidir_en_reg;
   assign bidir_pin_oe_o            = bidir_en_reg;
   assign dedicated_output_pin_o    = ded_out_reg & ded_en_reg;
   assign dedicated_output_pin_oe_o = ded_en_reg;

   // read channel: one read in flight, answer one cycle after address
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= gpio_bank_pkg::REG_RESET;
         s_axi_rresp  <= gpio_bank_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= gpio_bank_pkg::RESP_OKAY;
         s_axi_rdata  <= '0;
         if (decode(s_axi_araddr) == 2'h1)
         begin
            // both set and clear fields show latch state
            s_axi_rdata[gpio_bank_pkg::BIDIR_OUT_CLR_LSB +: BIDIR_N] <= bidir_out_reg;
            s_axi_rdata[gpio_bank_pkg::BIDIR_OUT_SET_LSB +: BIDIR_N] <= bidir_out_reg;
            s_axi_rdata[gpio_bank_pkg::BIDIR_EN_CLR_LSB +: BIDIR_N]  <= bidir_en_reg;
            s_axi_rdata[gpio_bank_pkg::BIDIR_EN_SET_LSB +: BIDIR_N]  <= bidir_en_reg;
            s_axi_rdata[gpio_bank_pkg::BIDIR_IN_LSB +: BIDIR_N]      <= bidir_in_sync;
         end
         else if (decode(s_axi_araddr) == 2'h2)
         begin
            s_axi_rdata[gpio_bank_pkg::DED_OUT_CLR_LSB +: DED_N] <= ded_out_reg;
            s_axi_rdata[gpio_bank_pkg::DED_OUT_SET_LSB +: DED_N] <= ded_out_reg;
            s_axi_rdata[gpio_bank_pkg::DED_EN_CLR_LSB +: DED_N]  <= ded_en_reg;
            s_axi_rdata[gpio_bank_pkg::DED_EN_SET_LSB +: DED_N]  <= ded_en_reg;
            s_axi_rdata[gpio_bank_pkg::DED_IN_LSB +: DED_N]      <= ded_in_sync;
         end
         else
         begin
            // unmapped
            s_axi_rresp <= gpio_bank_pkg::RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // checks on the register behaviour
   bidir_clr_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      wr_bidir && wbits[0] && !wbits[3] |=> !bidir_out_reg[0])
      else $error("bidir clear did not drop latch");
   bidir_set_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      wr_bidir && wbits[3] |=> bidir_out_reg[0])
      else $error("bidir set did not raise latch");
   bidir_en_clr_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      wr_bidir && wbits[6] && !wbits[9] |=> !bidir_pin_oe_o[0])
      else $error("bidir enable clear failed");
   bidir_en_set_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      wr_bidir && wbits[11] |=> bidir_pin_oe_o[2])
      else $error("bidir enable set failed");
   ded_clr_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      wr_ded && wbits[1] && !wbits[5] |=> !ded_out_reg[1])
      else $error("dedicated clear failed");
   ded_set_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      wr_ded && wbits[7] |=> ded_out_reg[3])
      else $error("dedicated set failed");
   ded_en_clr_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      wr_ded && wbits[8] && !wbits[12] |=> !dedicated_output_pin_oe_o[0])
      else $error("dedicated enable clear failed");
   ded_en_set_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      wr_ded && wbits[15] |=> dedicated_output_pin_oe_o[3])
      else $error("dedicated enable set failed");
   ded_in_read_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      s_axi_arvalid && s_axi_arready && decode(s_axi_araddr) == 2'h2
      |=> s_axi_rdata[gpio_bank_pkg::DED_IN_LSB +: DED_N] == $past(ded_in_sync))
      else $error("dedicated input field not read back");
   pin_idle_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      !dedicated_output_pin_oe_o[0] |-> !dedicated_output_pin_o[0])
      else $error("disabled pin shows drive value");
   no_write_hold_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      !wr_bidir |=> bidir_out_reg == $past(bidir_out_reg))
      else $error("bidir latch changed without write");
   rd_answer_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");

   bidir_wr_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i) wr_bidir);
   ded_wr_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i) wr_ded);
   pin_drive_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
      bidir_pin_oe_o[1] && bidir_pin_o[1]);
   bad_rd_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
      s_axi_rvalid && s_axi_rresp == gpio_bank_pkg::RESP_SLVERR);
   part_wr_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
      wr_fire && wr_strb_eff != 4'hf);
endmodule
`default_nettype wire

// >>> gpio_pins_model.sv
// board-side model of the pins around the general-purpose pin bank
`default_nettype none
module gpio_pins_model (
   input  wire logic [2:0] bidir_pin_o,           // level the bank drives
   input  wire logic [2:0] bidir_pin_oe_o,        // high while the bank drives
   input  wire logic [2:0] ext_bidir_i,           // level the board drives when released
   input  wire logic [3:0] ext_ded_i,             // board levels on the dedicated inputs
   output logic      [2:0] bidir_pin_i,           // resolved wire level fed back
   output logic      [3:0] dedicated_input_pin_i  // dedicated input wires
);
   timeunit 1ns;
   timeprecision 1ps;
   // wire resolution: the bank wins only while its enable is high
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         bidir_pin_i[i] = bidir_pin_oe_o[i] ? bidir_pin_o[i] : ext_bidir_i[i];
      end
   end
   // dedicated inputs are plain board-driven lines
   assign dedicated_input_pin_i = ext_ded_i;
endmodule
`default_nettype wire

// >>> extended_gpio_gpo_gpi_bank_test.sv
// self-checking testbench for the general-purpose pin bank
`default_nettype none
module extended_gpio_gpo_gpi_bank_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk_i = 1'b0;   // 100 mhz core clock
   logic        resetn_i   = 1'b0;   // active-low reset
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [3:0]  wstrb  = 4'hf;       // whole words except the strobe test, which writes byte 0 only
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [2:0]  bid_o, bid_oe, bid_i;
   logic [3:0]  ded_o, ded_oe, ded_i;
   logic [2:0]  ext_b = 3'h0;        // board level on released bidir pins
   logic [3:0]  ext_d = 4'h0;        // board level on dedicated inputs
   logic [2:0]  b_lat = 3'h0, b_en = 3'h0; // expected bidir latch and enable
   logic [3:0]  d_lat = 4'h0, d_en = 4'h0; // expected dedicated latch and enable
   int          n_errors = 0, checked = 0, cycles = 0;
   localparam logic [31:0] BA = {20'h0, gpio_bank_pkg::BIDIR_REG_ADDR};
   localparam logic [31:0] DA = {20'h0, gpio_bank_pkg::DEDICATED_REG_ADDR};
   localparam logic [1:0]  OK = gpio_bank_pkg::RESP_OKAY;
   localparam logic [1:0]  SE = gpio_bank_pkg::RESP_SLVERR;

   // clock generator
   always #5 core_clk_i = ~core_clk_i;

   gpio_bank u_dut (
      .core_clk_i(core_clk_i), .resetn_i(resetn_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .bidir_pin_i(bid_i), .bidir_pin_o(bid_o), .bidir_pin_oe_o(bid_oe),
      .dedicated_output_pin_o(ded_o), .dedicated_output_pin_oe_o(ded_oe),
      .dedicated_input_pin_i(ded_i)
   );

   gpio_pins_model u_pins (
      .bidir_pin_o(bid_o), .bidir_pin_oe_o(bid_oe), .ext_bidir_i(ext_b), .ext_ded_i(ext_d),
      .bidir_pin_i(bid_i), .dedicated_input_pin_i(ded_i)
   );

   // expected read words: set and clear fields both show the state
   function automatic logic [31:0] exp_b();
      logic [2:0] lvl;
      lvl = (b_en & b_lat) | (~b_en & ext_b);
      return {17'h0, lvl, b_en, b_en, b_lat, b_lat};
   endfunction
   function automatic logic [31:0] exp_d();
      return {12'h0, ext_d, d_en, d_en, d_lat, d_lat};
   endfunction

   // compare and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // verdict and end of run
   task automatic end_of_test();
      $display("checked=%0d n_errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // hang guard
   always @(posedge core_clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         end_of_test();
      end
   end

   // axi4-lite write, then time for input synchronisers to settle
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      logic done;
      done = 1'b0;
      @(posedge core_clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done)
      begin
         @(posedge core_clk_i);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid)
         begin
            done = 1'b1;
            bready <= 1'b0;
            chk({30'h0, bresp}, {30'h0, er});
         end
      end
      repeat (4) @(posedge core_clk_i);
   endtask

   // axi4-lite read with expected data and response
   task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic done;
      done = 1'b0;
      @(posedge core_clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done)
      begin
         @(posedge core_clk_i);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid)
         begin
            done = 1'b1;
            rready <= 1'b0;
            chk(rdata, ed);
            chk({30'h0, rresp}, {30'h0, er});
         end
      end
   endtask

   // pins against expected latch and enable state
   task automatic pins();
      chk({29'h0, bid_o}, {29'h0, b_lat & b_en});
      chk({29'h0, bid_oe}, {29'h0, b_en});
      chk({28'h0, ded_o}, {28'h0, d_lat & d_en});
      chk({28'h0, ded_oe}, {28'h0, d_en});
   endtask

   // main sequence
   initial
   begin
      repeat (3) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      rd(BA, 32'h0, OK);
      rd(DA, 32'h0, OK);
      pins();
      ext_b <= 3'h2;
      ext_d <= 4'h9;
      // enable all bidir pins, set latches 0 and 2
      wr(BA, (32'h7 << gpio_bank_pkg::BIDIR_EN_SET_LSB) | (32'h5 << 3), OK);
      b_en = 3'h7;
      b_lat = 3'h5;
      rd(BA, exp_b(), OK);
      pins();
      // clear latch 0 and enable 2, other bits written as zero
      wr(BA, 32'h1 | (32'h4 << gpio_bank_pkg::BIDIR_EN_CLR_LSB), OK);
      b_lat = 3'h4;
      b_en = 3'h3;
      rd(BA, exp_b(), OK);
      pins();
      // write to the input field is ignored
      wr(BA, 32'h7 << gpio_bank_pkg::BIDIR_IN_LSB, OK);
      rd(BA, exp_b(), OK);
      // set and clear of one bit in one write: set wins
      wr(BA, (32'h1 << gpio_bank_pkg::BIDIR_OUT_SET_LSB) | 32'h1, OK);
      b_lat = 3'h5;
      rd(BA, exp_b(), OK);
      // byte strobes: only byte 0 lands, enable set in byte 1 is masked
      wstrb <= 4'h1;
      wr(BA, (32'h4 << gpio_bank_pkg::BIDIR_EN_SET_LSB) | 32'h1, OK);
      wstrb <= 4'hf;
      b_lat = 3'h4;
      rd(BA, exp_b(), OK);
      pins();
      // dedicated group: enable all, set latches 1 and 3
      wr(DA, (32'hf << gpio_bank_pkg::DED_EN_SET_LSB) | (32'ha << 4), OK);
      d_en = 4'hf;
      d_lat = 4'ha;
      rd(DA, exp_d(), OK);
      pins();
      wr(DA, 32'h2 | (32'h1 << gpio_bank_pkg::DED_EN_CLR_LSB), OK);
      d_lat = 4'h8;
      d_en = 4'he;
      rd(DA, exp_d(), OK);
      pins();
      // live input levels, input field writes ignored
      ext_d <= 4'h6;
      wr(DA, 32'hf << gpio_bank_pkg::DED_IN_LSB, OK);
      rd(DA, exp_d(), OK);
      // unmapped address answers with an error and changes nothing
      wr(32'h308, 32'hffff_ffff, SE);
      rd(32'h308, 32'h0, SE);
      rd(BA, exp_b(), OK);
      rd(DA, exp_d(), OK);
      end_of_test();
   end
endmodule
`default_nettype wire
